// ---- pkg/aacs_pkg.sv ----
// What this block does
// RULE_01: ack sequence number copied from receive store
// RULE_02: ack frame overwrites transmit store first
// RULE_03: ack sent after tx delay plus extension
// RULE_04: delay extension writable while running
// RULE_05: auto-ack listens, then frame-received interrupt
// RULE_06: ack sent, frame-sent interrupt, back to ready
// RULE_07: assessment retry limit zero to five
// RULE_08: channel access off: send after MAC delay
// RULE_09: host times assessments, retry count one
// RULE_10: ack-request bit 5 at base plus one
// RULE_11: command starts procedure, interrupt ends it
// RULE_12: random backoff periods of 320 us
// RULE_13: each assessment measures for 128 us
// RULE_14: busy channel retries while limit not reached
// RULE_15: busy at limit aborts to ready
// RULE_16: clear channel goes straight to transmit
// RULE_17: receive to transmit takes at least 106 us
// RULE_18: no ack wanted: ready after transmit; with CTRL_LISTEN set the code first listens for the ack window
// RULE_19: else listen up to 864 us for ack
// RULE_20: ack timeout retries frame or exits ready
// RULE_21: every procedure exit raises completion interrupt
// RULE_22: ack only for filtered, non-beacon, non-ack, requested
// RULE_23: auto-ack needs frame filtering enabled
// RULE_24: backoff count from pseudo-random generator
// RULE_25: frame retry limit setting, counter cleared at start
package aacs_pkg;
  // register byte offsets
  localparam logic [4:0] OFF_CTRL   = 5'h00;
  localparam logic [4:0] OFF_DELAY  = 5'h04;
  localparam logic [4:0] OFF_RETRY  = 5'h08;
  localparam logic [4:0] OFF_BASE   = 5'h0C;
  localparam logic [4:0] OFF_CMD    = 5'h10;
  localparam logic [4:0] OFF_STATUS = 5'h14;
  // reset values and writable masks
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK  = 32'h0000_007F;
  localparam logic [31:0] DELAY_RST  = 32'h0000_00C0;
  localparam logic [31:0] DELAY_MASK = 32'h0000_FFFF;
  localparam logic [31:0] RETRY_RST  = 32'h0000_0034;
  localparam logic [31:0] RETRY_MASK = 32'h0000_0077;
  localparam logic [31:0] BASE_RST   = 32'h0000_8000;
  localparam logic [31:0] BASE_MASK  = 32'h0000_FFFF;
  // control and command bit positions
  localparam int CTRL_AUTO_ACK = 0;
  localparam int CTRL_FILTER   = 1;
  localparam int CTRL_CSMA     = 2;
  localparam int CTRL_LISTEN   = 3;
  localparam int CTRL_RX_IE    = 4;
  localparam int CTRL_TX_IE    = 5;
  localparam int CTRL_CA_IE    = 6;
  localparam int CMD_CA        = 0;
  localparam int CMD_RX        = 1;
  localparam int CMD_READY     = 2;
  localparam int ACK_REQ_BIT   = 5;
  // clock in MHz, timing in microseconds
  localparam int CLK_MHZ     = 200;
  localparam int BACKOFF_US  = 320;
  localparam int CCA_US      = 128;
  localparam int RX2TX_US    = 106;
  localparam int ACK_WAIT_US = 864;
  // channel access limits
  localparam logic [2:0] MIN_BE      = 3'h3;
  localparam logic [2:0] MAX_BE      = 3'h5;
  localparam logic [2:0] CCA_MAX_LIM = 3'h5;
  // frame layout and codes
  localparam logic [2:0] FT_BEACON = 3'h0;
  localparam logic [2:0] FT_ACK    = 3'h2;
  localparam logic [7:0] ACK_LEN   = 8'h05;
  localparam logic [7:0] ACK_FCF0  = 8'h02;
  localparam logic [7:0] ACK_FCF1  = 8'h00;
  localparam logic [7:0] SEQ_OFS   = 8'h03;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;
  // result codes
  localparam logic [1:0] RES_OK    = 2'h0;
  localparam logic [1:0] RES_BUSY  = 2'h1;
  localparam logic [1:0] RES_NOACK = 2'h2;
  localparam logic [1:0] RES_ABORT = 2'h3;

  typedef struct packed {
    logic       filter_ok;
    logic       ack_req;
    logic [2:0] ftype;
  } aacs_rx_info_t;

  typedef enum logic [3:0] {
    ST_READY, ST_ACK_LISTEN, ST_ACK_BUILD, ST_ACK_DLY, ST_ACK_TX,
    ST_CA_CHK, ST_CA_BO, ST_CA_CCA, ST_CA_TURN, ST_CA_MAC,
    ST_CA_TX, ST_CA_ACKWAIT
  } aacs_state_t;
endpackage

// ---- design/aacs_sequencer.sv ----
// Our own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/10ps
module aacs_sequencer #(
  parameter int US_CYC       = aacs_pkg::CLK_MHZ,
  parameter int BACKOFF_CYC  = aacs_pkg::BACKOFF_US * aacs_pkg::CLK_MHZ,
  parameter int CCA_CYC      = aacs_pkg::CCA_US * aacs_pkg::CLK_MHZ,
  parameter int TURN_CYC     = aacs_pkg::RX2TX_US * aacs_pkg::CLK_MHZ,
  parameter int ACK_WAIT_CYC = aacs_pkg::ACK_WAIT_US * aacs_pkg::CLK_MHZ
) (
  input  wire logic                    CLK_SYS_IN,
  input  wire logic                    RESET_IN,
  input  wire logic [4:0]              AVS_ADDRESS_IN,
  input  wire logic                    AVS_READ_IN,
  input  wire logic                    AVS_WRITE_IN,
  input  wire logic [31:0]             AVS_WRITEDATA_IN,
  input  wire logic [3:0]              AVS_BYTEENABLE_IN,
  output logic [31:0]                  AVS_READDATA_OUT,
  output logic                         AVS_WAITREQUEST_OUT,
  input  wire logic                    RX_FRAME_IN,
  input  wire aacs_pkg::aacs_rx_info_t RX_FRAME_INFO_IN,
  input  wire logic                    TX_DONE_IN,
  input  wire logic                    CCA_CLEAR_IN,
  input  wire logic [7:0]              RX_RD_DATA_IN,
  input  wire logic [7:0]              TX_RD_DATA_IN,
  output logic [7:0]                   RX_RD_ADDR_OUT,
  output logic [7:0]                   TX_ADDR_OUT,
  output logic                         TX_WR_EN_OUT,
  output logic [7:0]                   TX_WR_DATA_OUT,
  output logic                         RX_ON_OUT,
  output logic                         TX_START_OUT,
  output logic                         CCA_START_OUT,
  output logic                         IRQ_RX_PKT_OUT,
  output logic                         IRQ_TX_SENT_OUT,
  output logic                         CHANNEL_ACCESS_DONE_IRQ_OUT
);
  // byte-lane merge for register writes
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  // backoff window mask, 2^be - 1
  function automatic logic [4:0] be_mask(input logic [2:0] be);
    return 5'((6'h01 << be) - 6'h01);
  endfunction

  aacs_pkg::aacs_state_t st;
  logic [31:0] ctrl;
  logic [31:0] dly;
  logic [31:0] retry;
  logic [31:0] base;
  logic [31:0] tcnt;
  logic [15:0] lfsr;
  logic [4:0]  bo_left;
  logic [2:0]  be;
  logic [2:0]  nb;
  logic [2:0]  fr_cnt;
  logic [1:0]  result;
  logic        ack_exp;

  // bus decode; a write lands on the edge where waitrequest is low
  wire        req      = AVS_READ_IN | AVS_WRITE_IN;
  wire        wr_now   = AVS_WRITE_IN & ~AVS_WAITREQUEST_OUT;
  wire        sel_ctrl = AVS_ADDRESS_IN == aacs_pkg::OFF_CTRL;
  wire        sel_dly  = AVS_ADDRESS_IN == aacs_pkg::OFF_DELAY;
  wire        sel_rty  = AVS_ADDRESS_IN == aacs_pkg::OFF_RETRY;
  wire        sel_base = AVS_ADDRESS_IN == aacs_pkg::OFF_BASE;
  wire        sel_cmd  = AVS_ADDRESS_IN == aacs_pkg::OFF_CMD;
  wire        sel_stat = AVS_ADDRESS_IN == aacs_pkg::OFF_STATUS;
  wire        cmd_wr   = wr_now & sel_cmd & AVS_BYTEENABLE_IN[0];
  wire        cmd_ca   = cmd_wr & AVS_WRITEDATA_IN[aacs_pkg::CMD_CA];
  wire        cmd_rx   = cmd_wr & AVS_WRITEDATA_IN[aacs_pkg::CMD_RX];
  wire        cmd_rdy  = cmd_wr & AVS_WRITEDATA_IN[aacs_pkg::CMD_READY];
  wire [31:0] status   = {20'h0_0000, nb, fr_cnt, result, 4'(st)};
  wire [31:0] rd_mux   = sel_ctrl ? ctrl : sel_dly ? dly : sel_rty ? retry :
                         sel_base ? base : sel_stat ? status : 32'h0000_0000;

  // control fields
  wire       auto_ack_en          = ctrl[aacs_pkg::CTRL_AUTO_ACK];
  wire       filter_en            = ctrl[aacs_pkg::CTRL_FILTER];
  wire       csma_en              = ctrl[aacs_pkg::CTRL_CSMA];
  wire       listen_after_tx_flag = ctrl[aacs_pkg::CTRL_LISTEN];
  wire       rx_irq_en            = ctrl[aacs_pkg::CTRL_RX_IE];
  wire       tx_irq_en            = ctrl[aacs_pkg::CTRL_TX_IE];
  wire       ca_irq_en            = ctrl[aacs_pkg::CTRL_CA_IE];
  wire [7:0] delay_setting_one    = dly[7:0];
  wire [7:0] delay_setting_two    = dly[15:8];
  wire [2:0] cca_fld              = retry[2:0];
  wire [2:0] frame_max            = retry[6:4];
  wire [7:0] tx_base              = base[7:0];
  wire [7:0] rx_base              = base[15:8];
  // out-of-range settings saturate rather than wrap
  wire [2:0] cca_lim = (cca_fld > aacs_pkg::CCA_MAX_LIM) ? aacs_pkg::CCA_MAX_LIM
                                                        : cca_fld; // see RULE_07

  // mac delay read live every cycle, so the extension may move mid-wait
  wire [31:0] mac_cyc = 32'(32'({1'b0, delay_setting_one} + {1'b0, delay_setting_two})
                            * 32'(US_CYC)); // see RULE_03 see RULE_04
  wire        in_dly  = (st == aacs_pkg::ST_ACK_DLY) || (st == aacs_pkg::ST_CA_MAC);
  wire [31:0] lim     = in_dly ? mac_cyc :
                        (st == aacs_pkg::ST_CA_BO)   ? 32'(BACKOFF_CYC) :
                        (st == aacs_pkg::ST_CA_CCA)  ? 32'(CCA_CYC) :
                        (st == aacs_pkg::ST_CA_TURN) ? 32'(TURN_CYC) : 32'(ACK_WAIT_CYC);
  wire        t_done  = (tcnt + 32'h0000_0001) >= lim;

  // acknowledgment qualification
  wire ack_due = auto_ack_en & filter_en & RX_FRAME_INFO_IN.filter_ok
               & RX_FRAME_INFO_IN.ack_req
               & (RX_FRAME_INFO_IN.ftype != aacs_pkg::FT_BEACON)
               & (RX_FRAME_INFO_IN.ftype != aacs_pkg::FT_ACK); // see RULE_22 see RULE_23
  wire is_ack  = RX_FRAME_IN & (RX_FRAME_INFO_IN.ftype == aacs_pkg::FT_ACK);
  wire in_ca   = (st >= aacs_pkg::ST_CA_CHK);
  wire [2:0] be_up = (be == aacs_pkg::MAX_BE) ? aacs_pkg::MAX_BE : be + 3'h1;

  // ack frame bytes: length, two control bytes, copied sequence number
  wire [7:0] ack_byte = (tcnt[1:0] == 2'h0) ? aacs_pkg::ACK_LEN :
                        (tcnt[1:0] == 2'h1) ? aacs_pkg::ACK_FCF0 :
                        (tcnt[1:0] == 2'h2) ? aacs_pkg::ACK_FCF1 : RX_RD_DATA_IN; // see RULE_01

  // bus slave: one wait state, read data captured with the answer
  always_ff @(posedge CLK_SYS_IN) begin
    if (RESET_IN) begin
      AVS_WAITREQUEST_OUT <= 1'b1;
      AVS_READDATA_OUT    <= 32'h0000_0000;
    end else begin
      AVS_WAITREQUEST_OUT <= ~(req & AVS_WAITREQUEST_OUT);
      if (req & AVS_WAITREQUEST_OUT) begin
        AVS_READDATA_OUT <= rd_mux;
      end
    end
  end

  // software registers
  always_ff @(posedge CLK_SYS_IN) begin
    if (RESET_IN) begin
      ctrl  <= aacs_pkg::CTRL_RST;
      dly   <= aacs_pkg::DELAY_RST;
      retry <= aacs_pkg::RETRY_RST;
      base  <= aacs_pkg::BASE_RST;
    end else if (wr_now) begin
      if (sel_ctrl) ctrl <= be_merge(ctrl, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN)
                            & aacs_pkg::CTRL_MASK;
      if (sel_dly) dly <= be_merge(dly, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN)
                          & aacs_pkg::DELAY_MASK;
      if (sel_rty) retry <= be_merge(retry, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN)
                            & aacs_pkg::RETRY_MASK;
      if (sel_base) base <= be_merge(base, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN)
                            & aacs_pkg::BASE_MASK;
    end
  end

  // free-running random source for backoff draws
  always_ff @(posedge CLK_SYS_IN) begin
    if (RESET_IN) begin
      lfsr <= aacs_pkg::LFSR_SEED;
    end else begin
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]}; // see RULE_24
    end
  end

  // radio sequencer; a ready command overrides any state
  always_ff @(posedge CLK_SYS_IN) begin
    if (RESET_IN) begin
      st              <= aacs_pkg::ST_READY;
      tcnt            <= 32'h0000_0000;
      bo_left         <= 5'h00;
      be              <= aacs_pkg::MIN_BE;
      nb              <= 3'h0;
      fr_cnt          <= 3'h0;
      result          <= aacs_pkg::RES_OK;
      ack_exp         <= 1'b0;
      RX_RD_ADDR_OUT  <= 8'h00;
      TX_ADDR_OUT     <= 8'h00;
      TX_WR_EN_OUT    <= 1'b0;
      TX_WR_DATA_OUT  <= 8'h00;
      RX_ON_OUT       <= 1'b0;
      TX_START_OUT    <= 1'b0;
      CCA_START_OUT   <= 1'b0;
      IRQ_RX_PKT_OUT  <= 1'b0;
      IRQ_TX_SENT_OUT <= 1'b0;
      CHANNEL_ACCESS_DONE_IRQ_OUT <= 1'b0;
    end else begin
      TX_WR_EN_OUT    <= 1'b0;
      TX_START_OUT    <= 1'b0;
      CCA_START_OUT   <= 1'b0;
      IRQ_RX_PKT_OUT  <= 1'b0;
      IRQ_TX_SENT_OUT <= 1'b0;
      CHANNEL_ACCESS_DONE_IRQ_OUT <= 1'b0;
      tcnt <= tcnt + 32'h0000_0001;
      if (cmd_rdy && st != aacs_pkg::ST_READY) begin
        st        <= aacs_pkg::ST_READY;
        RX_ON_OUT <= 1'b0;
        if (in_ca) begin
          result <= aacs_pkg::RES_ABORT;
          CHANNEL_ACCESS_DONE_IRQ_OUT <= ca_irq_en; // see RULE_21
        end
      end else begin
        case (st)
          aacs_pkg::ST_READY: begin
            if (cmd_ca) begin
              fr_cnt      <= 3'h0; // see RULE_25
              st          <= aacs_pkg::ST_CA_CHK; // see RULE_11
              tcnt        <= 32'h0000_0000;
              TX_ADDR_OUT <= tx_base + 8'h01;
            end else if (cmd_rx) begin
              st        <= aacs_pkg::ST_ACK_LISTEN;
              RX_ON_OUT <= 1'b1;
            end
          end
          aacs_pkg::ST_ACK_LISTEN: begin
            if (RX_FRAME_IN) begin
              RX_ON_OUT      <= 1'b0;
              IRQ_RX_PKT_OUT <= rx_irq_en; // see RULE_05
              tcnt           <= 32'h0000_0000;
              RX_RD_ADDR_OUT <= rx_base + aacs_pkg::SEQ_OFS;
              st <= ack_due ? aacs_pkg::ST_ACK_BUILD : aacs_pkg::ST_READY;
            end
          end
          aacs_pkg::ST_ACK_BUILD: begin
            // sequence byte is written last, after the store read settles
            TX_WR_EN_OUT   <= 1'b1; // see RULE_02
            TX_ADDR_OUT    <= tx_base + tcnt[7:0];
            TX_WR_DATA_OUT <= ack_byte;
            if (tcnt[1:0] == 2'h3) begin
              st   <= aacs_pkg::ST_ACK_DLY;
              tcnt <= 32'h0000_0000;
            end
          end
          aacs_pkg::ST_ACK_DLY: begin
            if (t_done) begin
              TX_START_OUT <= 1'b1; // see RULE_03
              st           <= aacs_pkg::ST_ACK_TX;
            end
          end
          aacs_pkg::ST_ACK_TX: begin
            if (TX_DONE_IN) begin
              IRQ_TX_SENT_OUT <= tx_irq_en; // see RULE_06
              st              <= aacs_pkg::ST_READY;
            end
          end
          aacs_pkg::ST_CA_CHK: begin
            if (tcnt[1:0] == 2'h2) begin
              ack_exp <= TX_RD_DATA_IN[aacs_pkg::ACK_REQ_BIT]; // see RULE_10
              nb      <= 3'h0;
              be      <= aacs_pkg::MIN_BE;
              bo_left <= lfsr[4:0] & be_mask(aacs_pkg::MIN_BE); // see RULE_12
              tcnt    <= 32'h0000_0000;
              st <= csma_en ? aacs_pkg::ST_CA_BO : aacs_pkg::ST_CA_MAC; // see RULE_08
            end
          end
          aacs_pkg::ST_CA_BO: begin
            if (bo_left == 5'h00) begin
              CCA_START_OUT <= 1'b1; // see RULE_13
              RX_ON_OUT     <= 1'b1;
              tcnt          <= 32'h0000_0000;
              st            <= aacs_pkg::ST_CA_CCA;
            end else if (t_done) begin
              bo_left <= bo_left - 5'h01; // see RULE_12
              tcnt    <= 32'h0000_0000;
            end
          end
          aacs_pkg::ST_CA_CCA: begin
            if (t_done) begin
              tcnt      <= 32'h0000_0000;
              RX_ON_OUT <= 1'b0;
              if (CCA_CLEAR_IN) begin
                st <= aacs_pkg::ST_CA_TURN; // see RULE_16
              end else if (nb < cca_lim) begin
                nb      <= nb + 3'h1; // see RULE_14
                be      <= be_up;
                bo_left <= lfsr[4:0] & be_mask(be_up); // see RULE_24
                st      <= aacs_pkg::ST_CA_BO;
              end else begin
                st     <= aacs_pkg::ST_READY; // see RULE_15
                result <= aacs_pkg::RES_BUSY;
                CHANNEL_ACCESS_DONE_IRQ_OUT <= ca_irq_en; // see RULE_21
              end
            end
          end
          aacs_pkg::ST_CA_TURN, aacs_pkg::ST_CA_MAC: begin
            if (t_done) begin
              TX_START_OUT <= 1'b1; // see RULE_17 see RULE_08
              st           <= aacs_pkg::ST_CA_TX;
            end
          end
          aacs_pkg::ST_CA_TX: begin
            if (TX_DONE_IN) begin
              IRQ_TX_SENT_OUT <= tx_irq_en;
              tcnt            <= 32'h0000_0000;
              if (ack_exp | listen_after_tx_flag) begin
                RX_ON_OUT <= 1'b1; // see RULE_19
                st        <= aacs_pkg::ST_CA_ACKWAIT;
              end else begin
                st     <= aacs_pkg::ST_READY; // see RULE_18
                result <= aacs_pkg::RES_OK;
                CHANNEL_ACCESS_DONE_IRQ_OUT <= ca_irq_en; // see RULE_21
              end
            end
          end
          aacs_pkg::ST_CA_ACKWAIT: begin
            if (is_ack || t_done) begin
              RX_ON_OUT <= 1'b0;
              tcnt      <= 32'h0000_0000;
              if (!is_ack && ack_exp && fr_cnt < frame_max) begin
                fr_cnt      <= fr_cnt + 3'h1; // see RULE_20
                TX_ADDR_OUT <= tx_base + 8'h01;
                st          <= aacs_pkg::ST_CA_CHK;
              end else begin
                st     <= aacs_pkg::ST_READY; // see RULE_20
                result <= (!is_ack && ack_exp) ? aacs_pkg::RES_NOACK : aacs_pkg::RES_OK;
                CHANNEL_ACCESS_DONE_IRQ_OUT <= ca_irq_en; // see RULE_21
              end
            end
          end
          default: begin
            st <= aacs_pkg::ST_READY;
          end
        endcase
      end
    end
  end

  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (RESET_IN);

  chk_seq_copy: assert property ((st == aacs_pkg::ST_ACK_BUILD && tcnt[1:0] == 2'h3 && !cmd_rdy)
      |=> TX_WR_EN_OUT && TX_WR_DATA_OUT == $past(RX_RD_DATA_IN)) // see RULE_01
    else $error("ack sequence byte not copied");
  chk_rx_irq: assert property ((st == aacs_pkg::ST_ACK_LISTEN && RX_FRAME_IN && !cmd_rdy)
      |=> IRQ_RX_PKT_OUT == $past(rx_irq_en)) // see RULE_05
    else $error("frame-received interrupt wrong");
  chk_no_ack_bad: assert property ((st == aacs_pkg::ST_ACK_LISTEN && RX_FRAME_IN
      && !ack_due && !cmd_rdy) |=> st == aacs_pkg::ST_READY) // see RULE_22
    else $error("ack built for unqualified frame");
  chk_cca_limit: assert property (st == aacs_pkg::ST_CA_CCA |-> nb <= cca_lim) // see RULE_07
    else $error("assessment retries over limit");
  chk_cca_len: assert property ((st == aacs_pkg::ST_CA_CCA && !cmd_rdy)
      ##1 (st != aacs_pkg::ST_CA_CCA) |-> $past(tcnt) == 32'(CCA_CYC - 1)) // see RULE_13
    else $error("assessment window length wrong");
  chk_turn_len: assert property ((st == aacs_pkg::ST_CA_TURN && !cmd_rdy)
      ##1 (st == aacs_pkg::ST_CA_TX) |-> $past(tcnt) >= 32'(TURN_CYC - 1)) // see RULE_17
    else $error("turnaround too short");
  chk_mac_start: assert property ((st == aacs_pkg::ST_CA_MAC && t_done && !cmd_rdy)
      |=> TX_START_OUT && st == aacs_pkg::ST_CA_TX) // see RULE_08
    else $error("no start after mac delay");
  chk_ack_window: assert property (st == aacs_pkg::ST_CA_ACKWAIT
      |-> tcnt < 32'(ACK_WAIT_CYC)) // see RULE_19
    else $error("ack wait overran");
  chk_done_irq: assert property ($fell(in_ca)
      |-> CHANNEL_ACCESS_DONE_IRQ_OUT == $past(ca_irq_en)) // see RULE_21
    else $error("exit without completion interrupt");
  chk_bus_wait: assert property ((req && AVS_WAITREQUEST_OUT)
      |=> !AVS_WAITREQUEST_OUT ##1 AVS_WAITREQUEST_OUT)
    else $error("waitrequest answer timing wrong");
endmodule

// ---- test/aacs_radio_model.sv ----
`timescale 1ns/10ps
// far-side radio: frame stores with a one-cycle read, fixed air time per frame
module aacs_radio_model (
  input  wire logic       clk_in,
  input  wire logic       tx_start_in,
  input  wire logic [7:0] tx_addr_in,
  input  wire logic       tx_wr_en_in,
  input  wire logic [7:0] tx_wr_data_in,
  input  wire logic [7:0] rx_rd_addr_in,
  output logic            tx_done_out,
  output logic [7:0]      tx_rd_data_out,
  output logic [7:0]      rx_rd_data_out
);
  logic [7:0] tx_mem [256];
  logic [7:0] rx_mem [256];
  int         air;
  // received frame carries sequence number 0xa5
  initial begin
    tx_done_out = 1'b0;
    air = 0;
    rx_mem[8'h83] = 8'hA5;
  end
  // ack bytes overwrite the stored frame; done only after a start
  always @(posedge clk_in) begin
    if (tx_wr_en_in) begin
      tx_mem[tx_addr_in] <= tx_wr_data_in;
    end
    tx_rd_data_out <= tx_mem[tx_addr_in];
    rx_rd_data_out <= rx_mem[rx_rd_addr_in];
    tx_done_out <= (air == 1);
    air <= tx_start_in ? 10 : (air > 0 ? air - 1 : 0);
  end
endmodule

// ---- test/auto_ack_csma_ca_sequencer_tb.sv ----
`timescale 1ns/10ps
module auto_ack_csma_ca_sequencer_tb;
  logic        clk, rst, rd, wr, rx_frame, cca_clr, tx_done, waitreq, tx_wr;
  logic        tx_start, irq_rx, irq_tx, irq_ca, rx_on, cca_st;
  logic [3:0]  ben;
  logic [4:0]  adr;
  logic [31:0] wd, rdata, q;
  logic [7:0]  rx_addr, tx_addr, tx_wd, tx_rdd, rx_rdd;
  aacs_pkg::aacs_rx_info_t info;
  int          fail_count, n_checks, cyc, n_tx, n_done, n_rxi, n_txi, t_rx, t_tx, k, n_cca;

  aacs_radio_model rm_u (.clk_in(clk), .tx_start_in(tx_start), .tx_addr_in(tx_addr),
    .tx_wr_en_in(tx_wr), .tx_wr_data_in(tx_wd), .rx_rd_addr_in(rx_addr),
    .tx_done_out(tx_done), .tx_rd_data_out(tx_rdd), .rx_rd_data_out(rx_rdd));
  // short counts keep the run brief; expectations use the same figures
  aacs_sequencer #(.US_CYC(2), .BACKOFF_CYC(20), .CCA_CYC(8), .TURN_CYC(6),
    .ACK_WAIT_CYC(40)) dut_u (.CLK_SYS_IN(clk), .RESET_IN(rst), .AVS_ADDRESS_IN(adr),
    .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd), .AVS_BYTEENABLE_IN(ben),
    .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(waitreq), .RX_FRAME_IN(rx_frame),
    .RX_FRAME_INFO_IN(info), .TX_DONE_IN(tx_done), .CCA_CLEAR_IN(cca_clr),
    .RX_RD_DATA_IN(rx_rdd), .TX_RD_DATA_IN(tx_rdd), .RX_RD_ADDR_OUT(rx_addr),
    .TX_ADDR_OUT(tx_addr), .TX_WR_EN_OUT(tx_wr), .TX_WR_DATA_OUT(tx_wd), .RX_ON_OUT(rx_on),
    .TX_START_OUT(tx_start), .CCA_START_OUT(cca_st), .IRQ_RX_PKT_OUT(irq_rx),
    .IRQ_TX_SENT_OUT(irq_tx), .CHANNEL_ACCESS_DONE_IRQ_OUT(irq_ca));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // event counters and a hang guard far above the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    n_done <= n_done + (irq_ca === 1'b1);
    n_rxi <= n_rxi + (irq_rx === 1'b1);
    n_txi <= n_txi + (irq_tx === 1'b1);
    n_cca <= n_cca + (cca_st === 1'b1);
    if (tx_start === 1'b1) begin
      n_tx <= n_tx + 1;
      t_tx <= cyc;
    end
    if (cyc == 20000) begin
      fail_count++;
      wrap_up();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic we, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= we;
    rd <= !we;
    adr <= a;
    wd <= d;
    @(posedge clk);
    while (waitreq !== 1'b0) @(posedge clk);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  // bounded wait for the n-th completion pulse
  task automatic wait_n(input int n);
    int i;
    for (i = 0; i < 4000 && n_done < n; i++) @(posedge clk);
  endtask
  task automatic frame(input logic [2:0] ft);
    @(posedge clk);
    info <= '{filter_ok: 1'b1, ack_req: 1'b1, ftype: ft};
    rx_frame <= 1'b1;
    t_rx <= cyc;
    @(posedge clk);
    rx_frame <= 1'b0;
  endtask
  task automatic wrap_up;
    if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    {rst, rd, wr, rx_frame, cca_clr} = 5'h1_F & 5'h10;
    {adr, wd, info} = '0;
    ben = 4'hF;
    {fail_count, n_checks, cyc, n_tx, n_done, n_rxi, n_txi, t_rx, t_tx, n_cca} = '0;
    idle(2);
    rst <= 1'b0;
    bus(1'b0, aacs_pkg::OFF_DELAY, '0);
    chk("delay reset", q, 32'h0000_00C0);
    bus(1'b0, aacs_pkg::OFF_RETRY, '0);
    chk("retry reset", q, 32'h0000_0034);
    bus(1'b0, 5'h1C, '0);
    chk("unmapped", q, 32'h0000_0000);
    // auto-ack: a beacon gets no ack, a data frame does
    bus(1'b1, aacs_pkg::OFF_CTRL, 32'h0000_0033);
    // two single-lane writes build the delay word; the second must leave the first write's lane alone
    ben <= 4'h2;
    bus(1'b1, aacs_pkg::OFF_DELAY, 32'h0000_01FF);
    ben <= 4'h1;
    bus(1'b1, aacs_pkg::OFF_DELAY, 32'h0000_FF01);
    ben <= 4'hF;
    bus(1'b0, aacs_pkg::OFF_DELAY, '0);
    chk("delay lanes", q, 32'h0000_0101);
    bus(1'b1, aacs_pkg::OFF_CMD, 32'h0000_0002);
    idle(3);
    chk("listening", rx_on, 1'b1);
    frame(aacs_pkg::FT_BEACON);
    idle(30);
    chk("beacon tx", n_tx, 0);
    chk("rx off", rx_on, 1'b0);
    bus(1'b1, aacs_pkg::OFF_CMD, 32'h0000_0002);
    idle(3);
    k = n_rxi;
    frame(3'h1);
    idle(60);
    chk("rx irq", n_rxi, k + 1);
    chk("ack tx", n_tx, 1);
    chk("tx irq", n_txi, 1);
    chk("ack len", rm_u.tx_mem[0], 8'h05);
    chk("ack fcf", rm_u.tx_mem[1], 8'h02);
    chk("ack seq", rm_u.tx_mem[3], 8'hA5);
    // frame edge, four store writes, start pulse edge, then (1 + 1) us at 2 cycles per us
    chk("ack delay", t_tx - t_rx, 6 + (1 + 1) * 2);
    bus(1'b0, aacs_pkg::OFF_STATUS, '0);
    chk("ready", q[3:0], 4'h0);
    // channel access, channel always busy, one assessment retry
    bus(1'b1, aacs_pkg::OFF_CTRL, 32'h0000_0044);
    bus(1'b1, aacs_pkg::OFF_RETRY, 32'h0000_0001);
    bus(1'b1, aacs_pkg::OFF_CMD, 32'h0000_0001);
    wait_n(1);
    bus(1'b0, aacs_pkg::OFF_STATUS, '0);
    chk("busy end", q[11:0], 12'h210);
    chk("busy no tx", n_tx, 1);
    chk("busy cca", n_cca, 2);
    // clear channel, ack wanted and never sent, one frame retry
    rm_u.tx_mem[1] = 8'h20;
    cca_clr <= 1'b1;
    bus(1'b1, aacs_pkg::OFF_RETRY, 32'h0000_0010);
    bus(1'b1, aacs_pkg::OFF_CMD, 32'h0000_0001);
    wait_n(2);
    bus(1'b0, aacs_pkg::OFF_STATUS, '0);
    chk("no ack end", q[11:0], 12'h060);
    chk("retried tx", n_tx, 3);
    chk("retry cca", n_cca, 4);
    // channel access off, no ack wanted, host keeps the retry count at one
    rm_u.tx_mem[1] = 8'h00;
    bus(1'b1, aacs_pkg::OFF_CTRL, 32'h0000_0040);
    bus(1'b1, aacs_pkg::OFF_RETRY, 32'h0000_0001);
    // a long extension is cut short mid-wait; the send must follow the new value
    bus(1'b1, aacs_pkg::OFF_DELAY, 32'h0000_FF01);
    bus(1'b1, aacs_pkg::OFF_CMD, 32'h0000_0001);
    k = cyc;
    idle(5);
    bus(1'b1, aacs_pkg::OFF_DELAY, 32'h0000_0101);
    wait_n(3);
    chk("live delay", (t_tx - k) < 30, 1'b1);
    bus(1'b0, aacs_pkg::OFF_STATUS, '0);
    chk("direct end", q[5:0], 6'h00);
    chk("direct tx", n_tx, 4);
    chk("direct cca", n_cca, 4);
    // go ready during the ack-request read, before the long mac wait starts, aborts the procedure and still completes
    bus(1'b1, aacs_pkg::OFF_DELAY, 32'h0000_FF01);
    bus(1'b1, aacs_pkg::OFF_CMD, 32'h0000_0001);
    bus(1'b1, aacs_pkg::OFF_CMD, 32'h0000_0004);
    wait_n(4);
    bus(1'b0, aacs_pkg::OFF_STATUS, '0);
    chk("abort end", q[5:0], 6'h30);
    chk("abort tx", n_tx, 4);
    chk("done irqs", n_done, 4);
    wrap_up();
  end
endmodule
